// ==== rtl/serial_slave_link_setup.sv ====
// Setup and supervision of a drive's serial slave port, AXI4-Lite reached.
// Assumes a frame receiver and transmitter on the same clock outside.
// How it works
// R1: Eight-bit station address, reset 1f, frames for other addresses ignored.
// R2: Address, rate and parity take effect only after power-up reset.
// R3: Rate codes 0..8 select 1200 through 115200 bps.
// R4: Default rate code is 2 for protocol 2, otherwise 3.
// R5: Flag error for protocol 1 not 9600, 2 not 4800, 3 at code 8.
// R6: Code 8 unavailable under protocols 0,1; only code 2 under protocol 2.
// R7: Parity 0 none, 1 even, 2 odd, reset none, eight data bits.
// R8: Loss stop action 0 ramp,1 coast,2 fast,3 alarm,4 preset; reset 3.
// R9: Ramp stop uses the deceleration time active at that moment.
// R10: Loss detect enable resets to 1; cleared, no loss fault ever.
// R11: No data longer than timeout raises loss fault and stop action.
// R12: Loss timeout 0.0 to 10.0 s in tenths, reset 2.0 s.
// R13: Response starts after configured transmit wait time elapses.
// R14: RTS control 1 asserts RTS only while sending; 0 keeps it on.
// R15: Protocol code 0..3, 0 Modbus default, 3 BACnet.
// R16: Voltage monitor word in 0.1 V units or 1 V units.
// R17: Commit mode 0 needs one commit after writes; 1 applies at once.
// R18: Run method 0 fwd/rev run bits; 1 run bit plus direction bit.
// R19: Status, terminals, parameters, faults, inputs always reachable.
// R20: Remote and terminal multi-function inputs are ORed.
// R21: Master pauses between messages to the same slave.
// R22: Master gives every slave a distinct station address.
// R23: Station 0 requests are broadcasts, executed with no response.
`timescale 1ns/1ps
`default_nettype none
`include "link_setup_map.svh"
module serial_slave_link_setup
  import link_setup_pkg::*;
#(
  parameter int unsigned TENTH = `TENTH_CYCLES,
  parameter int unsigned INPUTS = 8
) (
  // Clock, enable and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Frame receiver and transmitter
  input wire logic frame_valid,
  input wire logic [7:0] frame_addr,
  input wire logic rx_activity,
  input wire logic tx_busy,
  output logic frame_accept,
  output logic frame_reply,
  output logic tx_start,
  output logic rts,
  // Applied line settings
  output logic [7:0] station_address_setting,
  output logic [3:0] bit_rate_code,
  output logic [16:0] baud_rate,
  output parity_t parity_setting,
  output protocol_t protocol_select,
  output logic rate_protocol_config_error,
  // Drive side
  input wire logic [15:0] out_voltage_dv,
  input wire logic [INPUTS-1:0] terminal_inputs,
  output logic [INPUTS-1:0] multi_inputs,
  output logic run_fwd,
  output logic run_rev,
  output logic loss_fault,
  output stop_action_t stop_active,
  output logic use_active_decel,
  output logic preset_speed_four
);
  import link_setup_pkg::*;

  // Staged settings; the line ones stand for stored parameters, so they
  // start at their power-on values and survive reset
  logic [7:0] addr_r = `RST_ADDR; // R1
  logic [3:0] rate_r = 4'h3;
  logic [1:0] par_r = `RST_PARITY; // R7
  logic [1:0] prot_r = `RST_PROTOCOL; // R15
  logic rate_set_r = 1'b0;
  logic [2:0] act_r;
  logic len_r, rtsc_r, vu_r, cm_r, rm_r;
  logic [7:0] to_r;
  logic [15:0] wait_r;
  logic [1:0] cmd_r;
  logic [INPUTS-1:0] rin_r;
  // Effective values for commit-gated settings
  logic [2:0] act_e_r;
  logic len_e_r, rtsc_e_r, vu_e_r, rm_e_r;
  logic [7:0] to_e_r;
  logic [15:0] wait_e_r;
  // Power-up latched line settings
  logic [7:0] addr_a_r;
  logic [3:0] rate_a_r;
  logic [1:0] par_a_r, prot_a_r;
  logic boot_r, loss_clr_r;
  // Bus state
  logic aw_r, w_r, bv_r, rv_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r, rd_r;
  logic [1:0] br_r, rr_r;
  logic s_wstrb_q;
  // Terminal pins synchronised; only the second stage is read
  logic [INPUTS-1:0] term_m_r, term_s_r;
  // Response sequencer
  tx_state_t tx_r;
  logic [15:0] cnt_r;
  logic lost;

  // Default rate follows protocol at power-up R4
  wire [3:0] rate_default = (prot_r == PROT_BA_TWO) ? 4'h2 : 4'h3; // R4

  // Write path: accept address and data independently, answer after both
  wire aw_take = s_awvalid && !aw_r && !bv_r;
  wire w_take = s_wvalid && !w_r && !bv_r;
  wire do_wr = aw_r && w_r && !bv_r;
  wire [31:0] wd = wd_r;
  wire [7:0] wa = awa_r;
  wire map_w = (wa == `OFF_ADDR) || (wa == `OFF_LINE) ||
               (wa == `OFF_LOSS) || (wa == `OFF_RESP) ||
               (wa == `OFF_MODE) || (wa == `OFF_CMD) ||
               (wa == `OFF_COMMIT) || (wa == `OFF_STATUS);
  wire w_line = do_wr && wa == `OFF_LINE;
  wire w_loss = do_wr && wa == `OFF_LOSS;
  wire w_mode = do_wr && wa == `OFF_MODE;
  wire commit = do_wr && wa == `OFF_COMMIT && wd_r[0];
  wire [3:0] new_rate = wd[`LINE_RATE_LSB +: 4];
  wire [1:0] new_par = wd[`LINE_PAR_LSB +: 2];
  wire [7:0] new_to = wd[`LOSS_TO_LSB +: 8];
  wire [2:0] new_act = wd[2:0];
  // Out-of-range values are refused and the old setting kept
  wire rate_ok = new_rate <= `MAX_RATE; // R3
  wire par_ok = new_par != 2'h3; // R7
  wire act_ok = new_act <= `MAX_ACTION; // R8
  wire to_ok = new_to <= `MAX_TIMEOUT; // R12
  // Immediate apply unless commit mode 0 R17
  wire apply = cm_r || commit; // R17

  // Configuration check on the applied settings R5 R6
  wire cfg_err =
    (prot_a_r == PROT_BA_ONE && rate_a_r != 4'h3) || // R5
    (prot_a_r == PROT_BA_TWO && rate_a_r != 4'h2) || // R5
    (prot_a_r == PROT_BACNET && rate_a_r == `MAX_RATE) || // R5
    (prot_a_r == PROT_MODBUS && rate_a_r == `MAX_RATE) || // R6
    (rate_a_r > `MAX_RATE); // R6

  // Frame address filter and broadcast R1 R23
  wire is_bcast = frame_addr == 8'h00;
  assign frame_accept = frame_valid &&
                        (is_bcast || frame_addr == addr_a_r); // R1 R23
  assign frame_reply = frame_valid && !is_bcast &&
                       frame_addr == addr_a_r; // R23

  // Read mux
  wire [31:0] vmon = vu_e_r ? 32'(out_voltage_dv / 16'd10)
                            : 32'(out_voltage_dv); // R16
  wire [31:0] status_w = {16'h0, 7'h0, tx_r == TX_SEND, 2'h0,
                          rate_protocol_config_error, loss_fault,
                          run_rev, run_fwd, 2'h0};
  wire [7:0] ra = s_araddr;
  wire map_r = ra <= `OFF_COMMIT && ra[1:0] == 2'h0;
  wire [31:0] rmux =
    (ra == `OFF_ADDR) ? {24'h0, addr_r} :
    (ra == `OFF_LINE) ? {24'h0, prot_r, par_r, rate_r} :
    (ra == `OFF_LOSS) ? {16'h0, to_r, 4'h0, len_r, act_r} :
    (ra == `OFF_RESP) ? {16'h0, wait_r} :
    (ra == `OFF_MODE) ? {28'h0, rm_r, cm_r, vu_r, rtsc_r} :
    (ra == `OFF_CMD) ? {{(30-INPUTS){1'b0}}, rin_r, cmd_r} :
    (ra == `OFF_STATUS) ? status_w :
    (ra == `OFF_ACTIVE) ? {16'h0, prot_a_r, par_a_r, rate_a_r, addr_a_r} :
    (ra == `OFF_VMON) ? vmon :
    32'(term_s_r); // R19
  wire ar_take = s_arvalid && !rv_r;

  assign s_awready = !aw_r && !bv_r;
  assign s_wready = !w_r && !bv_r;
  assign s_bvalid = bv_r;
  assign s_bresp = br_r;
  assign s_arready = !rv_r;
  assign s_rvalid = rv_r;
  assign s_rdata = rd_r;
  assign s_rresp = rr_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      bv_r <= 1'b0;
      rv_r <= 1'b0;
      awa_r <= 8'h0;
      wd_r <= 32'h0;
      rd_r <= 32'h0;
      br_r <= 2'h0;
      rr_r <= 2'h0;
    end else if (clk_en) begin
      if (aw_take) begin
        aw_r <= 1'b1;
        awa_r <= s_awaddr;
      end
      if (w_take) begin
        w_r <= 1'b1;
        wd_r <= s_wdata;
      end
      if (do_wr) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        bv_r <= 1'b1;
        br_r <= map_w ? 2'h0 : 2'h2;
      end else if (bv_r && s_bready)
        bv_r <= 1'b0;
      if (ar_take) begin
        rv_r <= 1'b1;
        rd_r <= map_r ? rmux : 32'h0;
        rr_r <= map_r ? 2'h0 : 2'h2;
      end else if (rv_r && s_rready)
        rv_r <= 1'b0;
    end
  end

  // Software-written settings; byte lane 0 gates each register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_r <= `RST_ACTION; // R8
      len_r <= `RST_LOSS_EN; // R10
      to_r <= `RST_TIMEOUT; // R12
      wait_r <= `RST_RESP_WAIT; // R13
      rtsc_r <= `RST_RTS_CTL; // R14
      vu_r <= 1'b0;
      cm_r <= 1'b0;
      rm_r <= 1'b0;
      cmd_r <= 2'h0;
      rin_r <= '0;
    end else if (clk_en && do_wr && s_wstrb_q) begin
      if (wa == `OFF_ADDR)
        addr_r <= wd[7:0];
      if (wa == `OFF_LINE) begin
        if (par_ok)
          par_r <= new_par;
        prot_r <= wd[`LINE_PROT_LSB +: 2]; // R15
      end
      if (w_loss) begin
        if (act_ok)
          act_r <= new_act;
        len_r <= wd[`LOSS_EN_BIT];
        if (to_ok)
          to_r <= new_to;
      end
      if (wa == `OFF_RESP)
        wait_r <= wd[15:0];
      if (w_mode) begin
        rtsc_r <= wd[`MODE_RTS_BIT];
        vu_r <= wd[`MODE_VU_BIT];
        cm_r <= wd[`MODE_CM_BIT];
        rm_r <= wd[`MODE_RM_BIT];
      end
      if (wa == `OFF_CMD) begin
        cmd_r <= wd[1:0]; // R19
        rin_r <= wd[2 +: INPUTS];
      end
    end
  end

  // Byte lane 0 strobe captured with the data
  always_ff @(posedge aclk) begin
    if (!aresetn)
      s_wstrb_q <= 1'b0;
    else if (clk_en && w_take)
      s_wstrb_q <= s_wstrb[0];
  end

  // Two flops on the terminal pins; not reset, they only follow the pins
  always_ff @(posedge aclk) begin
    if (clk_en) begin
      term_m_r <= terminal_inputs;
      term_s_r <= term_m_r;
    end
  end

  // Until software sets a rate, the power-up default follows the protocol
  always_ff @(posedge aclk) begin
    if (aresetn && clk_en && w_line && s_wstrb_q && rate_ok) begin
      rate_r <= new_rate; // R3
      rate_set_r <= 1'b1;
    end
  end

  // Commit-gated copies and power-up capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_e_r <= `RST_ACTION;
      len_e_r <= `RST_LOSS_EN;
      to_e_r <= `RST_TIMEOUT;
      wait_e_r <= `RST_RESP_WAIT;
      rtsc_e_r <= `RST_RTS_CTL;
      vu_e_r <= 1'b0;
      rm_e_r <= 1'b0;
      boot_r <= 1'b1;
      addr_a_r <= `RST_ADDR;
      rate_a_r <= 4'h3;
      par_a_r <= `RST_PARITY;
      prot_a_r <= `RST_PROTOCOL;
      loss_clr_r <= 1'b0;
    end else if (clk_en) begin
      boot_r <= 1'b0;
      // Power-up capture of the stored line settings
      if (boot_r) begin
        addr_a_r <= addr_r; // R2
        rate_a_r <= rate_set_r ? rate_r : rate_default; // R2 R4
        par_a_r <= par_r; // R2
        prot_a_r <= prot_r; // R2
      end
      if (apply) begin
        act_e_r <= act_r;
        len_e_r <= len_r;
        to_e_r <= to_r;
        wait_e_r <= wait_r;
        rtsc_e_r <= rtsc_r;
        vu_e_r <= vu_r;
        rm_e_r <= rm_r;
      end
      loss_clr_r <= do_wr && wa == `OFF_STATUS && wd_r[3];
    end
  end

  loss_timer #(
    .TENTH(TENTH)
  ) u_loss (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .enable(len_e_r), // R10
    .timeout(to_e_r), // R12
    .rx_activity(rx_activity), // R11
    .clear(loss_clr_r),
    .lost(lost)
  );

  // Response wait then transmit; RTS follows the sequencer under RTS control 1, else held on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_r <= TX_IDLE;
      cnt_r <= 16'h0;
    end else if (clk_en) begin
      unique case (tx_r)
        TX_IDLE: begin
          if (frame_reply) begin
            tx_r <= TX_WAIT;
            cnt_r <= wait_e_r; // R13
          end
        end
        TX_WAIT: begin
          if (cnt_r == 16'h0)
            tx_r <= TX_SEND; // R13
          else
            cnt_r <= cnt_r - 16'h1;
        end
        TX_SEND: begin
          if (!tx_busy)
            tx_r <= TX_IDLE;
        end
      endcase
    end
  end
  assign tx_start = (tx_r == TX_WAIT) && (cnt_r == 16'h0); // R13
  assign rts = rtsc_e_r ? (tx_r == TX_SEND) : 1'b1; // R14

  // Loss reaction R8 R9 R11
  wire stopping = lost && act_e_r != STOP_ALARM; // R11
  assign loss_fault = lost; // R11
  assign stop_active = lost ? stop_action_t'(act_e_r) : STOP_ALARM; // R8
  assign use_active_decel = lost && act_e_r == STOP_RAMP; // R9
  assign preset_speed_four = lost && act_e_r == STOP_PRESET; // R8

  // Run command decoding R18
  wire run_req = rm_e_r ? cmd_r[0] : (cmd_r[0] ^ cmd_r[1]); // R18
  wire rev_dir = rm_e_r ? cmd_r[1] : cmd_r[1]; // R18
  assign run_fwd = run_req && !rev_dir && (!stopping || preset_speed_four);
  assign run_rev = run_req && rev_dir && (!stopping || preset_speed_four);
  assign multi_inputs = term_s_r | rin_r; // R20

  // Applied line settings
  assign station_address_setting = addr_a_r; // R1
  assign bit_rate_code = rate_a_r;
  assign parity_setting = parity_t'(par_a_r); // R7
  assign protocol_select = protocol_t'(prot_a_r); // R15
  assign rate_protocol_config_error = cfg_err; // R5
  assign baud_rate =
    (rate_a_r == 4'h0) ? 17'd1200 : (rate_a_r == 4'h1) ? 17'd2400 :
    (rate_a_r == 4'h2) ? 17'd4800 : (rate_a_r == 4'h3) ? 17'd9600 :
    (rate_a_r == 4'h4) ? 17'd19200 : (rate_a_r == 4'h5) ? 17'd38400 :
    (rate_a_r == 4'h6) ? 17'd57600 : (rate_a_r == 4'h7) ? 17'd76800 :
    17'd115200; // R3
endmodule
`default_nettype wire

// ==== common/link_setup_map.svh ====
// Offsets, field positions, reset values and timing counts of the setup block.
// Assumes inclusion by bare name from design files only.
`ifndef LINK_SETUP_MAP_SVH
`define LINK_SETUP_MAP_SVH

// Register byte offsets
`define OFF_ADDR      8'h00
`define OFF_LINE      8'h04
`define OFF_LOSS      8'h08
`define OFF_RESP      8'h0c
`define OFF_MODE      8'h10
`define OFF_CMD       8'h14
`define OFF_STATUS    8'h18
`define OFF_ACTIVE    8'h1c
`define OFF_VMON      8'h20
`define OFF_COMMIT    8'h24

// Line register fields: rate [3:0], parity [5:4], protocol [7:6]
`define LINE_RATE_LSB 0
`define LINE_PAR_LSB  4
`define LINE_PROT_LSB 6
// Loss register: action [2:0], enable [3], timeout tenths [15:8]
`define LOSS_EN_BIT   3
`define LOSS_TO_LSB   8
// Mode register: rts ctl [0], volt unit [1], commit mode [2], run method [3]
`define MODE_RTS_BIT  0
`define MODE_VU_BIT   1
`define MODE_CM_BIT   2
`define MODE_RM_BIT   3

// Reset values and upper limits
`define RST_ADDR      8'h1f
`define RST_PARITY    2'h0
`define RST_PROTOCOL  2'h0
`define RST_ACTION    3'h3
`define RST_LOSS_EN   1'h1
`define RST_TIMEOUT   8'h14
`define RST_RTS_CTL   1'h1
`define RST_RESP_WAIT 16'h0018
`define MAX_TIMEOUT   8'h64
`define MAX_RATE      4'h8
`define MAX_ACTION    3'h4

// One tenth of a second in cycles at 25 MHz
`define CLK_HZ        25000000
`define TENTH_CYCLES  (`CLK_HZ / 10)

`endif

// ==== common/link_setup_pkg.sv ====
// Types shared by the serial slave setup block.
// Assumes the map header supplies the numeric constants.
package link_setup_pkg;
  typedef enum logic [2:0] {
    STOP_RAMP = 3'h0,
    STOP_COAST = 3'h1,
    STOP_FAST = 3'h2,
    STOP_ALARM = 3'h3,
    STOP_PRESET = 3'h4
  } stop_action_t;

  typedef enum logic [1:0] {
    PROT_MODBUS = 2'h0,
    PROT_BA_ONE = 2'h1,
    PROT_BA_TWO = 2'h2,
    PROT_BACNET = 2'h3
  } protocol_t;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_ODD = 2'h2
  } parity_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_SEND = 3'b100
  } tx_state_t;
endpackage

// ==== rtl/loss_timer.sv ====
// Communication-loss watchdog counting tenths of a second since last data.
// Assumes rx_activity is a same-clock pulse from the receiver.
`timescale 1ns/1ps
`default_nettype none
`include "link_setup_map.svh"
module loss_timer #(
  parameter int unsigned TENTH = `TENTH_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // Control
  input wire logic enable,
  input wire logic [7:0] timeout,
  input wire logic rx_activity,
  input wire logic clear,
  // Result
  output logic lost
);
  logic [22:0] sub_r;
  logic [7:0] tenths_r;
  logic lost_r;
  wire tick = (sub_r == 23'(TENTH - 1));
  wire expire = enable && (tenths_r >= timeout) && tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_r <= 23'h0;
      tenths_r <= 8'h0;
      lost_r <= 1'b0;
    end else if (clk_en) begin
      if (rx_activity || !enable) begin
        sub_r <= 23'h0;
        tenths_r <= 8'h0;
      end else begin
        sub_r <= tick ? 23'h0 : sub_r + 23'h1;
        if (tick && tenths_r != 8'hff)
          tenths_r <= tenths_r + 8'h1;
      end
      // Set wins over clear; a disabled detector never faults
      if (!enable)
        lost_r <= 1'b0;
      else if (expire)
        lost_r <= 1'b1;
      else if (clear)
        lost_r <= 1'b0;
    end
  end
  assign lost = lost_r;
endmodule
`default_nettype wire

// ==== verification/link_setup_monitor.sv ====
// Concurrent checks on the ports of the serial slave setup block.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module link_setup_monitor #(
  parameter int unsigned INPUTS = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Frame side
  input wire logic frame_valid,
  input wire logic [7:0] frame_addr,
  input wire logic tx_busy,
  input wire logic frame_accept,
  input wire logic frame_reply,
  input wire logic rts,
  // Applied settings
  input wire logic [7:0] station_address_setting,
  input wire logic [3:0] bit_rate_code,
  input wire link_setup_pkg::protocol_t protocol_select,
  input wire logic rate_protocol_config_error,
  // Drive side
  input wire logic [INPUTS-1:0] terminal_inputs,
  input wire logic [INPUTS-1:0] multi_inputs,
  input wire logic loss_fault,
  input wire link_setup_pkg::stop_action_t stop_active,
  input wire logic use_active_decel,
  input wire logic preset_speed_four,
  // Bus answers
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic s_rvalid,
  input wire logic s_rready
);
  import link_setup_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_bcast;
    frame_valid && frame_addr == 8'h00 |-> frame_accept && !frame_reply;
  endproperty
  a_bcast: assert property (p_bcast) else $error("broadcast answered");
  property p_own;
    frame_valid && |frame_addr && frame_addr == station_address_setting
      |-> frame_accept && frame_reply;
  endproperty
  a_own: assert property (p_own) else $error("own frame dropped");
  property p_stranger;
    frame_valid && |frame_addr && frame_addr != station_address_setting
      |-> !frame_accept;
  endproperty
  a_stranger: assert property (p_stranger) else $error("foreign frame");
  property p_err;
    protocol_select != PROT_MODBUS |-> rate_protocol_config_error ==
      (protocol_select == PROT_BA_ONE ? bit_rate_code != 4'h3 :
       protocol_select == PROT_BA_TWO ? bit_rate_code != 4'h2 :
       bit_rate_code == 4'h8);
  endproperty
  a_err: assert property (p_err) else $error("config error wrong");
  // Applied line settings move only in reset and its capture edge
  property p_hold;
    $past(aresetn, 2) && $past(aresetn) |->
      $stable({station_address_setting, bit_rate_code, protocol_select});
  endproperty
  a_hold: assert property (p_hold) else $error("setting moved");
  property p_rts;
    tx_busy |-> rts;
  endproperty
  a_rts: assert property (p_rts) else $error("rts low while sending");
  property p_or;
    ($past(terminal_inputs, 2) & ~multi_inputs) == '0;
  endproperty
  a_or: assert property (p_or) else $error("terminal input lost");
  property p_ramp;
    loss_fault && stop_active == STOP_RAMP |-> use_active_decel;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp without decel");
  property p_preset;
    loss_fault && stop_active == STOP_PRESET |-> preset_speed_four;
  endproperty
  a_preset: assert property (p_preset) else $error("no preset run");
  property p_bhold;
    s_bvalid && !s_bready |=> s_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rhold;
    s_rvalid && !s_rready |=> s_rvalid;
  endproperty
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  c_bcast: cover property (frame_valid && frame_addr == 8'h00);
  c_loss: cover property ($rose(loss_fault));
  c_err: cover property ($rose(rate_protocol_config_error));
endmodule
bind serial_slave_link_setup link_setup_monitor #(.INPUTS(INPUTS)) i_mon (.*);
`default_nettype wire

// ==== verification/link_master_model.sv ====
// Serial master and frame transceiver seen from the setup block.
// Assumes the bench calls request and may lengthen send_len.
`timescale 1ns/1ps
`default_nettype none
module link_master_model (
  // Clock
  input wire logic aclk,
  // Frame side
  input wire logic tx_start,
  output logic frame_valid,
  output logic [7:0] frame_addr,
  output logic rx_activity,
  output logic tx_busy
);
  int send_len = 6;
  int left = 0;
  initial begin
    frame_valid = 1'b0;
    frame_addr = 8'h00;
    rx_activity = 1'b0;
  end
  // Quiet gap first, so a slave is never overrun by back-to-back frames
  task automatic request(input logic [7:0] a);
    repeat (4) @(posedge aclk);
    repeat (3) begin
      rx_activity <= 1'b1;
      @(posedge aclk);
      rx_activity <= 1'b0;
      @(posedge aclk);
    end
    frame_valid <= 1'b1;
    frame_addr <= a;
    @(posedge aclk);
    frame_valid <= 1'b0;
    frame_addr <= ~a;
  endtask
  always @(posedge aclk)
    if (tx_start) left <= send_len;
    else if (left > 0) left <= left - 1;
  assign tx_busy = left > 0;
endmodule
`default_nettype wire

// ==== verification/test_serial_slave_link_setup.sv ====
// Self-checking bench for the serial slave setup block.
// Assumes the master model beside it and the bound monitor.
`timescale 1ns/1ps
`default_nettype none
module test_serial_slave_link_setup;
  import link_setup_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic frame_valid, rx_activity, tx_busy, frame_accept, frame_reply;
  logic tx_start, rts, rate_protocol_config_error;
  logic [7:0] frame_addr, station_address_setting;
  logic [3:0] bit_rate_code;
  logic [16:0] baud_rate;
  parity_t parity_setting;
  protocol_t protocol_select;
  logic [15:0] out_voltage_dv = 16'h0900;
  logic [7:0] terminal_inputs = 8'ha5, multi_inputs;
  logic run_fwd, run_rev, loss_fault, use_active_decel, preset_speed_four;
  stop_action_t stop_active;
  int miscompares = 0;
  int checked = 0;
  int unsigned bps[9] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600,
    76800, 115200};
  logic [1:0] runx[7] = '{2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0, 2'h1};
  serial_slave_link_setup #(.TENTH(10)) i_dut (.*);
  link_master_model i_master (.*);
  always #20 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic rst(input int n);
    aresetn <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
    // Line settings are captured at the first edge, seen after the second
    repeat (2) @(posedge aclk);
  endtask
  // Optional commit afterwards, since staged parameters wait for one
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit c);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
    @(posedge aclk);
    if (c) wr(8'h24, 32'h1, 1'b0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d & m, e);
    chk(r, 2'h0);
  endtask
  // Cycles from the end of a frame until the reply starts; 200 means none
  task automatic ask(input logic [7:0] a, output int n);
    i_master.request(a);
    n = 0;
    while (tx_start !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    repeat (60) @(posedge aclk);
  endtask
  task automatic t_defaults;
    chk(station_address_setting, 8'h1f);
    chk(bit_rate_code, 4'h3);
    chk(parity_setting, PAR_NONE);
    chk(protocol_select, PROT_MODBUS);
    chk(rts, 1'b0);
    rc(8'h08, 32'hffff, 32'h140b);
    rc(8'h0c, 32'hffff, 32'h18);
    rc(8'h10, 32'hf, 32'h1);
  endtask
  task automatic t_line;
    logic [1:0] p;
    wr(8'h00, 32'h42, 1'b1);
    chk(station_address_setting, 8'h1f);
    for (int c = 0; c <= 8; c++) begin
      p = 2'(c % 3);
      wr(8'h04, {24'h0, 2'h3, p, 4'(c)}, 1'b1);
      chk(bit_rate_code, c == 0 ? 32'h3 : 32'(c - 1));
      rst(2);
      chk(baud_rate, bps[c]);
      chk(parity_setting, p);
      chk(protocol_select, PROT_BACNET);
      chk(rate_protocol_config_error, c == 8);
    end
    chk(station_address_setting, 8'h42);
    for (int k = 0; k < 3; k++) begin
      wr(8'h04, k == 0 ? 32'h44 : k == 1 ? 32'h43 : 32'h82, 1'b1);
      rst(2);
      chk(rate_protocol_config_error, k == 0);
    end
  endtask
  task automatic t_frames;
    int n24, n5, n;
    ask(8'h42, n24);
    chk(n24 < 200, 1'b1);
    ask(8'h00, n);
    chk(n, 32'hc8);
    ask(8'h17, n);
    chk(n, 32'hc8);
    wr(8'h0c, 32'h5, 1'b0);
    ask(8'h42, n);
    chk(n, n24);
    wr(8'h24, 32'h1, 1'b0);
    i_master.send_len = 40;
    ask(8'h42, n5);
    chk(n24 - n5, 32'h13);
    chk(rts, 1'b0);
    wr(8'h10, 32'h0, 1'b1);
    chk(rts, 1'b1);
  endtask
  task automatic t_loss;
    for (int a = 0; a <= 4; a++) begin
      wr(8'h08, 32'h0508 | a, 1'b1);
      i_master.request(8'h17);
      wr(8'h18, 32'h8, 1'b0);
      repeat (35) @(posedge aclk);
      chk(loss_fault, 1'b0);
      repeat (40) @(posedge aclk);
      chk(loss_fault, 1'b1);
      chk(stop_active, a);
    end
    wr(8'h08, 32'h0503, 1'b1);
    i_master.request(8'h17);
    wr(8'h18, 32'h8, 1'b0);
    repeat (150) @(posedge aclk);
    chk(loss_fault, 1'b0);
  endtask
  task automatic t_drive;
    logic [31:0] d;
    logic [1:0] r;
    rc(8'h20, 32'hffff, 32'h900);
    wr(8'h10, 32'h3, 1'b1);
    rc(8'h20, 32'hffff, 32'he6);
    chk(multi_inputs, 8'ha5);
    for (int k = 0; k < 7; k++) begin
      if (k == 0 || k == 3) wr(8'h10, k == 0 ? 32'h1 : 32'h9, 1'b1);
      wr(8'h14, k < 3 ? 32'(k) : 32'(k - 3), 1'b0);
      chk({run_fwd, run_rev}, runx[k]);
    end
    wr(8'h14, 32'h168, 1'b0);
    chk(multi_inputs, 8'hff);
    rd(8'h3c, d, r);
    chk(r, 2'h2);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst(10);
    t_defaults();
    t_line();
    t_frames();
    t_loss();
    t_drive();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    $display("Error at %0t ns: watchdog expired", $time);
    report_and_stop();
  end
endmodule
`default_nettype wire
